// >>> flash_mailbox_cfg.svh
// Constants for the self-programming flash mailbox: register offsets,
// field positions, command codes and operation times.
// Assumes a single 25 MHz core clock; times are converted to cycles here.
`ifndef FLASH_MAILBOX_CFG_SVH
`define FLASH_MAILBOX_CFG_SVH

// Special-function register offsets
`define SFR_CONFIG          8'hb1
`define SFR_COMMAND         8'hb2
`define SFR_ADDR_LOW        8'hb3
`define SFR_ADDR_HIGH       8'hb4
`define SFR_DATA            8'hb5
`define SFR_STATUS          8'hb6

// Field positions
`define CFG_ENABLE_BIT      6
`define CMD_IRQ_BIT         7
`define ST_OP_BUSY_BIT      2
`define ST_BYTE_BUSY_BIT    3
`define ADDR_BLOCK_BIT      7

// Reset values
`define RESET_BYTE          8'h00

// Command codes, low seven bits of the command byte
`define CMD_CHIP_ERASE      7'h01
`define CMD_BLOCK_ERASE     7'h0d
`define CMD_SECTOR_ERASE    7'h0b
`define CMD_BYTE_PROG       7'h0e
`define CMD_BURST_PROG      7'h06
`define CMD_BYTE_VERIFY     7'h0c
`define CMD_PROG_SB_A       7'h05
`define CMD_PROG_SB_B       7'h03
`define CMD_PROG_SB_C       7'h0f
`define CMD_PROG_RB_LOW     7'h08
`define CMD_PROG_RB_HIGH    7'h09
`define ERASE_KEY           8'h55
`define BLOCK1_NIBBLE       4'hf

// Sector and row geometry, as address low-bit masks
`define SECTOR_MASK_BLK0    16'h007f
`define SECTOR_MASK_BLK1    16'h003f
`define ROW_MASK_BLK0       16'h003f
`define ROW_MASK_BLK1       16'h001f
`define ROW_LAST_BLK0       7'h3f
`define ROW_LAST_BLK1       7'h1f

// Times in ns, and cycle counts derived from them
`define CLK_PERIOD_NS       40
`define T_CHIP_ERASE_NS     11700000
`define T_BLOCK_ERASE_NS    9400000
`define T_SECTOR_ERASE_NS   2300000
`define T_BYTE_PROG_NS      110000
`define T_BURST_BYTE_NS     45000
`define T_BURST_TIMEOUT_NS  20000
`define CYC_MAX(ns)         ((ns) / `CLK_PERIOD_NS)
`define CYC_MIN(ns)         (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_W             20
`define GAP_W               10

`endif

// >>> flash_mailbox_pkg.sv
// Types shared by the flash mailbox and its operation timer.
// Assumes flash_mailbox_cfg.svh is compiled with it.
`include "flash_mailbox_cfg.svh"

package flash_mailbox_pkg;

    typedef enum logic [2:0] {
        op_none, op_chip_erase, op_block_erase, op_sector_erase,
        op_byte_prog, op_burst_prog, op_read, op_fuse
    } flash_op_e;

    typedef enum logic [1:0] {
        st_idle, st_timing, st_read, st_burst_gap
    } seq_state_e;

    // Request to the flash array
    typedef struct packed {
        logic        req;
        flash_op_e   op;
        logic        block;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } flash_cmd_s;

    typedef struct packed {
        logic [`TIMER_W-1:0] cnt;
        logic                run;
        logic                done;
    } timer_s;

    typedef struct packed {
        logic [7:0]          prog_cfg;
        logic [7:0]          command;
        logic [7:0]          addr_high;
        logic [7:0]          addr_low;
        logic [7:0]          data;
        logic                op_busy;
        logic                byte_busy;
        seq_state_e          state;
        flash_op_e           cur_op;
        logic [6:0]          cur_code;
        logic                cur_block;
        logic [2:0]          sec_bits;
        logic [1:0]          remap;
        logic [1:0]          map_en;
        logic                map_loaded;
        logic [15:0]         burst_row;
        logic [6:0]          burst_left;
        logic [`GAP_W-1:0]   gap_cnt;
        logic                timer_start;
        logic [`TIMER_W-1:0] timer_load;
        logic [7:0]          sfr_rdata;
        flash_cmd_s          flash;
        logic                irq;
        logic                pin_sync1;
        logic                pin_sync2;
        logic                ext_irq_req;
        logic                code_read_fail;
    } mailbox_s;

endpackage : flash_mailbox_pkg

// >>> flash_op_timer.sv
// Erase and program duration timer, the internal timing oscillator.
// Assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/100ps
`include "flash_mailbox_cfg.svh"

module flash_op_timer (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // Control
    input  wire logic                start,
    input  wire logic [`TIMER_W-1:0] load,
    // Status
    output logic                     running,
    output logic                     done
);

    flash_mailbox_pkg::timer_s q, d;

    // Counts only while an operation needs it, stops at the end
    always_comb begin
        d      = q;
        d.done = 1'b0;
        if (start) begin
            d.cnt = load;
            d.run = 1'b1;
        end else if (q.run) begin
            if (q.cnt <= `TIMER_W'(1)) begin
                d.run  = 1'b0;
                d.done = 1'b1;
                d.cnt  = '0;
            end else begin
                d.cnt = q.cnt - `TIMER_W'(1);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign running = q.run;
    assign done    = q.done;

endmodule : flash_op_timer

// >>> self_program_flash_mailbox.sv
// Self-programming flash mailbox: special-function registers through which
// the core erases, programs and verifies its own flash while running.
// Assumes the flash array executes flash_cmd requests and returns read data
// on flash_rdata in the cycle after a read request.
//
// Behaviour
// - Commands are ignored until configuration bit 6 enables decoding.
// - Only a write to the command register starts an operation.
// - Commands except chip erase and security or remap programming are refused on a locked block.
// - The unit times every erase and program itself.
// - Code 01h with data 55h erases both blocks, security and remap bits.
// - Code 0Dh with 55h erases block 0 or block 1 by address high bits.
// - Code 0Bh erases a 128-byte or 64-byte sector at the address.
// - Code 0Eh programs the data register into the addressed byte.
// - Code 06h programs a row byte by byte from the data register.
// - During a burst only further burst bytes and no code reads are valid.
// - Security commands only set unprogrammed bits, effective at completion.
// - Remap commands change stored remap bits; map enables follow at reset.
// - Code 0Ch reads the addressed byte into the data register.
// - Status bit 2 is high during an operation, low when ready.
// - Status bit 3 drops between burst bytes to request the next one.
// - A code read aimed at a busy block fails.
// - Command bit 7 selects completion interrupt instead of polling only.
// - In interrupt mode the interrupt-1 pin no longer feeds the interrupt.
// - Completion interrupt needs its enable, global enable and edge select.
// - The timing oscillator runs only during an operation.
`timescale 1ns/100ps
`include "flash_mailbox_cfg.svh"

module self_program_flash_mailbox #(
    parameter logic [`TIMER_W-1:0] CHIP_ERASE_CYC  =
        `TIMER_W'(`CYC_MAX(`T_CHIP_ERASE_NS)),
    parameter logic [`TIMER_W-1:0] BLOCK_ERASE_CYC =
        `TIMER_W'(`CYC_MAX(`T_BLOCK_ERASE_NS)),
    parameter logic [`TIMER_W-1:0] SECTOR_ERASE_CYC =
        `TIMER_W'(`CYC_MAX(`T_SECTOR_ERASE_NS))
) (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // Special-function register port
    input  wire logic [7:0]                    sfr_addr,
    input  wire logic                          sfr_wr,
    input  wire logic [7:0]                    sfr_wdata,
    output logic [7:0]                         sfr_rdata,
    // Flash array
    output flash_mailbox_pkg::flash_cmd_s      flash_cmd,
    input  wire logic [7:0]                    flash_rdata,
    // Code read checks
    input  wire logic                          code_read_req,
    input  wire logic [7:0]                    code_read_addr_high,
    output logic                               code_read_fail,
    // Interrupt controller
    input  wire logic                          irq_one_enable,
    input  wire logic                          global_irq_enable,
    input  wire logic                          irq_one_edge_select,
    input  wire logic                          ext_irq_one_pin,
    output logic                               completion_interrupt,
    output logic                               ext_irq_one_request,
    // Security and map state
    output logic [2:0]                         security_bits,
    output logic [1:0]                         map_enable,
    output logic                               timing_osc_run
);

    localparam logic [`TIMER_W-1:0] BYTE_PROG_CYC  =
        `TIMER_W'(`CYC_MAX(`T_BYTE_PROG_NS));
    localparam logic [`TIMER_W-1:0] BURST_BYTE_CYC =
        `TIMER_W'(`CYC_MAX(`T_BURST_BYTE_NS));
    localparam logic [`GAP_W-1:0]   BURST_GAP_CYC  =
        `GAP_W'(`CYC_MIN(`T_BURST_TIMEOUT_NS));

    flash_mailbox_pkg::mailbox_s q, d;
    logic                        timer_done;

    // Block decode of an address high byte: {valid, block}
    function automatic logic [1:0] block_of(input logic [7:0] ah);
        if (!ah[`ADDR_BLOCK_BIT]) begin
            block_of = 2'h2;
        end else if (ah[7:4] == `BLOCK1_NIBBLE) begin
            block_of = 2'h3;
        end else begin
            block_of = 2'h0;
        end
    endfunction : block_of

    // Lock state of a block: bit a locks block 1, bits b and c lock both
    function automatic logic locked(input logic blk, input logic [2:0] sb);
        locked = blk ? (|sb) : (sb[1] | sb[2]);
    endfunction : locked

    // Row base of an address within its block
    function automatic logic [15:0] row_of(input logic blk, input logic [15:0] a);
        row_of = a & ~(blk ? `ROW_MASK_BLK1 : `ROW_MASK_BLK0);
    endfunction : row_of

    flash_op_timer u_timer (
        .clk     (clk),
        .rst     (rst),
        .start   (q.timer_start),
        .load    (q.timer_load),
        .running (timing_osc_run),
        .done    (timer_done)
    );

    always_comb begin
        logic                        cmd_write;
        logic [6:0]                  code;
        logic [1:0]                  blk_dec;
        logic [15:0]                 addr;
        logic                        launch;
        flash_mailbox_pkg::flash_op_e launch_op;
        logic [`TIMER_W-1:0]         launch_cyc;
        logic [15:0]                 launch_addr;
        logic                        finish;
        logic [1:0]                  rd_dec;

        d             = q;
        cmd_write     = 1'b0;
        code          = sfr_wdata[6:0];
        blk_dec       = block_of(q.addr_high);
        addr          = {q.addr_high, q.addr_low};
        launch        = 1'b0;
        launch_op     = flash_mailbox_pkg::op_none;
        launch_cyc    = BYTE_PROG_CYC;
        launch_addr   = addr;
        finish        = 1'b0;
        rd_dec        = block_of(code_read_addr_high);
        d.flash.req   = 1'b0;
        d.timer_start = 1'b0;
        d.irq         = 1'b0;

        // Interrupt-1 pin synchroniser; disconnected in interrupt mode
        d.pin_sync1   = ext_irq_one_pin;
        d.pin_sync2   = q.pin_sync1;
        d.ext_irq_req = q.command[`CMD_IRQ_BIT] ? 1'b0 : q.pin_sync2;

        // Map enables take the stored remap field once after reset
        if (!q.map_loaded) begin
            d.map_en     = q.remap;
            d.map_loaded = 1'b1;
        end

        // Code reads fail on a busy block or during a burst
        d.code_read_fail = 1'b0;
        if (code_read_req) begin
            if (q.op_busy && q.cur_op == flash_mailbox_pkg::op_burst_prog) begin
                d.code_read_fail = 1'b1;
            end else if (q.op_busy && rd_dec[1] &&
                         (q.cur_op == flash_mailbox_pkg::op_chip_erase ||
                          rd_dec[0] == q.cur_block)) begin
                d.code_read_fail = 1'b1;
            end
        end

        // Register reads
        if (sfr_addr == `SFR_CONFIG) begin
            d.sfr_rdata = q.prog_cfg;
        end else if (sfr_addr == `SFR_COMMAND) begin
            d.sfr_rdata = q.command;
        end else if (sfr_addr == `SFR_ADDR_LOW) begin
            d.sfr_rdata = q.addr_low;
        end else if (sfr_addr == `SFR_ADDR_HIGH) begin
            d.sfr_rdata = q.addr_high;
        end else if (sfr_addr == `SFR_DATA) begin
            d.sfr_rdata = q.data;
        end else if (sfr_addr == `SFR_STATUS) begin
            d.sfr_rdata = `RESET_BYTE;
            d.sfr_rdata[`ST_OP_BUSY_BIT]   = q.op_busy;
            d.sfr_rdata[`ST_BYTE_BUSY_BIT] = q.byte_busy;
        end else begin
            d.sfr_rdata = `RESET_BYTE;
        end

        // Register writes
        if (sfr_wr) begin
            if (sfr_addr == `SFR_CONFIG) begin
                d.prog_cfg = sfr_wdata;
            end else if (sfr_addr == `SFR_COMMAND) begin
                cmd_write = q.prog_cfg[`CFG_ENABLE_BIT];
            end else if (sfr_addr == `SFR_ADDR_LOW) begin
                d.addr_low = sfr_wdata;
            end else if (sfr_addr == `SFR_ADDR_HIGH) begin
                d.addr_high = sfr_wdata;
            end else if (sfr_addr == `SFR_DATA) begin
                d.data = sfr_wdata;
            end
        end

        case (q.state)
            flash_mailbox_pkg::st_idle: begin
                if (cmd_write) begin
                    if (code == `CMD_CHIP_ERASE) begin
                        if (q.data == `ERASE_KEY) begin
                            launch     = 1'b1;
                            launch_op  = flash_mailbox_pkg::op_chip_erase;
                            launch_cyc = CHIP_ERASE_CYC;
                        end
                    end else if (code == `CMD_PROG_SB_A || code == `CMD_PROG_SB_B ||
                                 code == `CMD_PROG_SB_C || code == `CMD_PROG_RB_LOW ||
                                 code == `CMD_PROG_RB_HIGH) begin
                        launch    = 1'b1;
                        launch_op = flash_mailbox_pkg::op_fuse;
                    end else if (code == `CMD_BLOCK_ERASE || code == `CMD_SECTOR_ERASE ||
                                 code == `CMD_BYTE_PROG || code == `CMD_BURST_PROG ||
                                 code == `CMD_BYTE_VERIFY) begin
                        if (blk_dec[1] && !locked(blk_dec[0], q.sec_bits)) begin
                            launch = 1'b1;
                            if (code == `CMD_BLOCK_ERASE) begin
                                launch     = (q.data == `ERASE_KEY);
                                launch_op  = flash_mailbox_pkg::op_block_erase;
                                launch_cyc = BLOCK_ERASE_CYC;
                            end else if (code == `CMD_SECTOR_ERASE) begin
                                launch_op   = flash_mailbox_pkg::op_sector_erase;
                                launch_cyc  = SECTOR_ERASE_CYC;
                                launch_addr = addr & ~(blk_dec[0] ? `SECTOR_MASK_BLK1
                                                                  : `SECTOR_MASK_BLK0);
                            end else if (code == `CMD_BYTE_PROG) begin
                                launch_op = flash_mailbox_pkg::op_byte_prog;
                            end else if (code == `CMD_BURST_PROG) begin
                                launch_op    = flash_mailbox_pkg::op_burst_prog;
                                launch_cyc   = BURST_BYTE_CYC;
                                d.burst_row  = row_of(blk_dec[0], addr);
                                d.burst_left = blk_dec[0] ? `ROW_LAST_BLK1 : `ROW_LAST_BLK0;
                            end else begin
                                launch_op = flash_mailbox_pkg::op_read;
                            end
                        end
                    end
                end
                if (launch) begin
                    d.command   = sfr_wdata;
                    d.cur_code  = code;
                    d.cur_op    = launch_op;
                    d.cur_block = blk_dec[0];
                    d.op_busy   = 1'b1;
                    d.byte_busy = 1'b1;
                    d.flash.req   = (launch_op != flash_mailbox_pkg::op_fuse);
                    d.flash.op    = launch_op;
                    d.flash.block = blk_dec[0];
                    d.flash.addr  = launch_addr;
                    d.flash.wdata = q.data;
                    if (launch_op == flash_mailbox_pkg::op_read) begin
                        d.state = flash_mailbox_pkg::st_read;
                    end else begin
                        d.state       = flash_mailbox_pkg::st_timing;
                        d.timer_start = 1'b1;
                        d.timer_load  = launch_cyc;
                    end
                end
            end
            flash_mailbox_pkg::st_timing: begin
                if (timer_done) begin
                    if (q.cur_op == flash_mailbox_pkg::op_chip_erase) begin
                        d.sec_bits = '0;
                        d.remap    = '0;
                        finish     = 1'b1;
                    end else if (q.cur_op == flash_mailbox_pkg::op_fuse) begin
                        if (q.cur_code == `CMD_PROG_SB_A) begin
                            d.sec_bits[0] = 1'b1;
                        end else if (q.cur_code == `CMD_PROG_SB_B) begin
                            d.sec_bits[1] = 1'b1;
                        end else if (q.cur_code == `CMD_PROG_SB_C) begin
                            d.sec_bits[2] = 1'b1;
                        end else if (q.cur_code == `CMD_PROG_RB_LOW) begin
                            d.remap[0] = 1'b1;
                        end else begin
                            d.remap[1] = 1'b1;
                        end
                        finish = 1'b1;
                    end else if (q.cur_op == flash_mailbox_pkg::op_burst_prog &&
                                 q.burst_left != 7'h00) begin
                        d.state      = flash_mailbox_pkg::st_burst_gap;
                        d.byte_busy  = 1'b0;
                        d.gap_cnt    = BURST_GAP_CYC;
                        d.burst_left = q.burst_left - 7'h01;
                    end else begin
                        finish = 1'b1;
                    end
                end
            end
            flash_mailbox_pkg::st_read: begin
                d.data = q.flash.req ? d.data : flash_rdata;
                finish = !q.flash.req;
            end
            flash_mailbox_pkg::st_burst_gap: begin
                if (cmd_write && code == `CMD_BURST_PROG &&
                    row_of(q.cur_block, addr) == q.burst_row) begin
                    d.command     = sfr_wdata;
                    d.byte_busy   = 1'b1;
                    d.state       = flash_mailbox_pkg::st_timing;
                    d.timer_start = 1'b1;
                    d.timer_load  = BURST_BYTE_CYC;
                    d.flash.req   = 1'b1;
                    d.flash.op    = flash_mailbox_pkg::op_burst_prog;
                    d.flash.addr  = addr;
                    d.flash.wdata = q.data;
                end else if (q.gap_cnt <= `GAP_W'(1)) begin
                    finish = 1'b1;
                end else begin
                    d.gap_cnt = q.gap_cnt - `GAP_W'(1);
                end
            end
            default: begin
                d.state = flash_mailbox_pkg::st_idle;
            end
        endcase

        if (finish) begin
            d.state     = flash_mailbox_pkg::st_idle;
            d.op_busy   = 1'b0;
            d.byte_busy = 1'b0;
            d.irq       = q.command[`CMD_IRQ_BIT] & irq_one_enable &
                          global_irq_enable & irq_one_edge_select;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sfr_rdata            = q.sfr_rdata;
    assign flash_cmd            = q.flash;
    assign code_read_fail       = q.code_read_fail;
    assign completion_interrupt = q.irq;
    assign ext_irq_one_request  = q.ext_irq_req;
    assign security_bits        = q.sec_bits;
    assign map_enable           = q.map_en;

endmodule : self_program_flash_mailbox

// >>> flash_mailbox_properties.sv
// Concurrent checks on the ports of the flash mailbox.
// Assumes it is bound to the mailbox top and shares the cfg header.
`timescale 1ns/100ps
`include "flash_mailbox_cfg.svh"
module flash_mailbox_properties (
    // Clock and reset
    input wire logic                         clk,
    input wire logic                         rst,
    // Register port
    input wire logic [7:0]                   sfr_addr,
    input wire logic                         sfr_wr,
    // Flash array and code reads
    input wire flash_mailbox_pkg::flash_cmd_s flash_cmd,
    input wire logic                         code_read_req,
    input wire logic                         code_read_fail,
    // Interrupt and state
    input wire logic                         irq_one_enable,
    input wire logic                         global_irq_enable,
    input wire logic                         irq_one_edge_select,
    input wire logic                         completion_interrupt,
    input wire logic [2:0]                   security_bits,
    input wire logic [1:0]                   map_enable,
    input wire logic                         timing_osc_run
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic cmd_wr = sfr_wr && sfr_addr == `SFR_COMMAND;
    req_one_pulse_a: assert property (flash_cmd.req |=> !flash_cmd.req)
        else $error("request too long");
    req_after_cmd_a: assert property (flash_cmd.req |-> $past(cmd_wr) || $past(cmd_wr, 2))
        else $error("request without command");
    osc_follows_req_a: assert property (flash_cmd.req &&
        flash_cmd.op != flash_mailbox_pkg::op_read |-> ##[1:2] timing_osc_run)
        else $error("timing oscillator not started");
    osc_stops_done_a: assert property (completion_interrupt |-> !timing_osc_run)
        else $error("oscillator still running");
    irq_needs_enable_a: assert property (completion_interrupt |->
        irq_one_enable && global_irq_enable && irq_one_edge_select)
        else $error("interrupt while disabled");
    irq_single_pulse_a: assert property (completion_interrupt |=> !completion_interrupt)
        else $error("interrupt too long");
    read_fail_cause_a: assert property (code_read_fail |-> $past(code_read_req))
        else $error("failure without a read");
    map_after_reset_a: assert property (!$past(rst) |-> $stable(map_enable))
        else $error("map enables changed outside reset");
    sec_only_set_a: assert property (|($past(security_bits) & ~security_bits) |->
        flash_cmd.op == flash_mailbox_pkg::op_chip_erase)
        else $error("security bit cleared");
    cover property (completion_interrupt);
    cover property (code_read_fail);
    cover property (flash_cmd.req && flash_cmd.op == flash_mailbox_pkg::op_burst_prog);
endmodule : flash_mailbox_properties

// >>> flash_array_model.sv
// Behavioural flash array: read data is a fixed function of the address.
// Assumes reads are answered in the cycle after the request.
`timescale 1ns/100ps
module flash_array_model (
    // Clock
    input wire logic                          clk,
    // Request in, read data out
    input wire flash_mailbox_pkg::flash_cmd_s cmd,
    output logic [7:0]                        rdata
);
    initial rdata = 8'ha5;
    // Stale data is inverted every cycle so it is never mistaken for a reply
    always @(posedge clk)
        rdata <= (cmd.req && cmd.op == flash_mailbox_pkg::op_read) ?
                 cmd.addr[7:0] ^ cmd.addr[15:8] : ~rdata;
endmodule : flash_array_model

// >>> tb_self_program_flash_mailbox.sv
// Self-checking bench for the flash mailbox.
// Assumes the cfg header, package, designs and array model come first.
`timescale 1ns/100ps
`include "flash_mailbox_cfg.svh"
module tb_self_program_flash_mailbox;
    logic clk = 0, rst = 1, sfr_wr = 0, code_read_req = 0, code_read_fail, timing_osc_run;
    logic irq_one_enable = 1, global_irq_enable = 1, irq_one_edge_select = 1;
    logic ext_irq_one_pin = 1, ext_irq_one_request, completion_interrupt;
    logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, flash_rdata, code_read_addr_high = 0;
    logic [7:0] rv, ah, al, lf = 8'h47;
    logic [2:0] security_bits;
    logic [1:0] map_enable;
    flash_mailbox_pkg::flash_cmd_s flash_cmd, last;
    int mismatches = 0, total_checks = 0, irqs = 0, reqs = 0, n;
    always #20 clk = ~clk;
    self_program_flash_mailbox #(.CHIP_ERASE_CYC(20'd20), .BLOCK_ERASE_CYC(20'd20),
        .SECTOR_ERASE_CYC(20'd20)) u_self_program_flash_mailbox (.*);
    flash_array_model u_flash_array_model (.clk(clk), .cmd(flash_cmd), .rdata(flash_rdata));
    always @(posedge clk) begin
        if (completion_interrupt === 1'b1) irqs++;
        if (flash_cmd.req === 1'b1) begin
            reqs++;
            last = flash_cmd;
        end
    end
    function automatic logic [7:0] nx(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : nx
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        sfr_addr = ad; sfr_wdata = d; sfr_wr = 1;
        @(posedge clk); #1;
    endtask : wr
    task automatic rd(input logic [7:0] ad);
        sfr_wr = 0; sfr_addr = ad;
        @(posedge clk); #1 rv = sfr_rdata;
    endtask : rd
    task automatic op(input logic [7:0] h, input logic [7:0] l, input logic [7:0] d,
                      input logic [7:0] c);
        wr(`SFR_ADDR_HIGH, h); wr(`SFR_ADDR_LOW, l); wr(`SFR_DATA, d); wr(`SFR_COMMAND, c);
        rd(`SFR_STATUS); rd(`SFR_STATUS);
    endtask : op
    task automatic idle(input int lim);
        repeat (3) rd(`SFR_STATUS);
        for (int i = 0; i < lim && rv[`ST_OP_BUSY_BIT] !== 1'b0; i++) rd(`SFR_STATUS);
        chk(rv[`ST_OP_BUSY_BIT], 0);
    endtask : idle
    task end_of_test;
        if (mismatches == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    initial begin
        #2400000 mismatches++;
        end_of_test();
    end
    initial begin
        repeat (3) @(posedge clk);
        #1 rst = 0;
        op(8'h01, 8'h00, 8'h12, 8'h0e);
        chk(rv, 8'h00);
        wr(`SFR_CONFIG, 8'h40);
        op(8'h00, 8'h00, 8'h55, 8'h01); idle(400);
        chk(last.op, flash_mailbox_pkg::op_chip_erase);
        for (int k = 0; k < 3; k++) begin
            lf = nx(lf); ah = lf & 8'h7f; lf = nx(lf); al = lf; lf = nx(lf);
            global_irq_enable = !k[0]; op(ah, al, lf, 8'h8e);
            chk(rv[`ST_OP_BUSY_BIT], 1);
            chk({last.op, last.addr, last.wdata}, {flash_mailbox_pkg::op_byte_prog, ah, al, lf});
            idle(3000); chk(ext_irq_one_request, 0);
            chk(irqs, k / 2 + 1);
            op(ah, al, 8'h00, 8'h0c); idle(10); rd(`SFR_DATA); chk(ext_irq_one_request, 1);
            chk(rv, ah ^ al);
        end
        op(8'h00, 8'h00, 8'h00, 8'h7f);
        chk(rv, 8'h00);
        op(8'hf3, 8'hc5, 8'h00, 8'h0b); idle(400);
        chk({last.op, last.addr}, {flash_mailbox_pkg::op_sector_erase, 16'hf3c0});
        op(8'h12, 8'hff, 8'h00, 8'h0b); idle(400);
        chk({last.op, last.addr}, {flash_mailbox_pkg::op_sector_erase, 16'h1280});
        op(8'hf5, 8'h00, 8'h55, 8'h0d); idle(400);
        chk({last.op, last.block}, {flash_mailbox_pkg::op_block_erase, 1'b1});
        op(8'h20, 8'h40, 8'ha1, 8'h06);
        for (int i = 0; i < 1500 && rv[`ST_BYTE_BUSY_BIT] !== 1'b0; i++) rd(`SFR_STATUS);
        chk(rv[3:2], 2'b01);
        code_read_req = 1; code_read_addr_high = 8'hf0;
        @(posedge clk); #1 code_read_req = 0;
        chk(code_read_fail, 1);
        n = reqs; wr(`SFR_COMMAND, 8'h0e); rd(`SFR_STATUS);
        chk(reqs, n);
        op(8'h20, 8'h41, 8'ha2, 8'h06);
        chk({last.addr, last.wdata}, {16'h2041, 8'ha2});
        idle(3000);
        op(8'h00, 8'h00, 8'h00, 8'h05); idle(3000);
        chk(security_bits, 3'b001);
        n = reqs; op(8'hf0, 8'h00, 8'h00, 8'h0e); idle(10);
        chk(reqs, n);
        op(8'h00, 8'h00, 8'h55, 8'h01); idle(400);
        chk(security_bits, 3'b000);
        op(8'h00, 8'h00, 8'h00, 8'h08); idle(3000);
        chk(map_enable, 2'b00);
        end_of_test();
    end
endmodule : tb_self_program_flash_mailbox
bind self_program_flash_mailbox flash_mailbox_properties u_flash_mailbox_properties (.*);
